// [core/pst_pkg.sv]
package pst_pkg;

    // register map, byte addresses on the apb
    localparam logic [11:0] CTRL_OFFSET      = 12'h000;
    localparam logic [11:0] STATUS_OFFSET    = 12'h004;

    // ctrl fields
    localparam int          CAP_LSB          = 0;
    localparam int          CAP_WIDTH        = 8;
    localparam logic [7:0]  CAP_RESET        = 8'h0a;

    // status fields
    localparam int          STAT_STATE_LSB   = 0;
    localparam int          STAT_ACTIVE_LSB  = 4;
    localparam int          STAT_LEVEL_LSB   = 8;
    localparam int          STAT_EN_BIT      = 12;
    localparam int          STAT_POL_BIT     = 13;
    localparam int          STAT_CHARGE_BIT  = 14;
    localparam int          STAT_TICKS_LSB   = 16;

    // timer clock: period per nanofarad and core rate
    localparam int unsigned TIMER_US_PER_NF  = 130;
    localparam int unsigned CORE_CLK_MHZ     = 40;
    localparam int unsigned CYC_PER_NF       = TIMER_US_PER_NF * CORE_CLK_MHZ;
    localparam int          PERIOD_WIDTH     = 24;

    // delays in timer periods
    localparam logic [3:0]  FIRST_TICKS      = 4'ha;
    localparam logic [3:0]  NEXT_TICKS       = 4'h8;

    typedef struct packed {
        logic rail_out_third;
        logic rail_out_second;
        logic rail_out_first;
    } pst_rail_type;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_UP_FIRST = 3'b001,
        ST_UP_SEC   = 3'b010,
        ST_UP_THIRD = 3'b011,
        ST_ON       = 3'b100,
        ST_DN_FIRST = 3'b101,
        ST_DN_NEXT  = 3'b110
    } pst_state_type;

endpackage : pst_pkg

// [core/pst_timer_osc.sv]
`timescale 1ns/1ps
module pst_timer_osc (
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    input  wire logic [pst_pkg::PERIOD_WIDTH-1:0] period,
    input  wire logic                            restart,
    output logic                                 charging,
    output logic                                 tick
);

    logic [pst_pkg::PERIOD_WIDTH-1:0] phase;
    logic [pst_pkg::PERIOD_WIDTH-1:0] next_phase;
    logic [pst_pkg::PERIOD_WIDTH-1:0] gap;
    logic                             clean;
    logic                             wrap;

    assign wrap = (phase >= period - 1'b1);

    always_comb begin
        if (restart || wrap) begin
            next_phase = '0;
        end else begin
            next_phase = phase + 1'b1;
        end
    end

    // phase zero is the start of a charging half
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase    <= '0;
            charging <= 1'b1;
            tick     <= 1'b0;
        end else begin
            phase    <= next_phase;
            charging <= (next_phase < (period >> 1));
            tick     <= wrap && !restart; // [RULE7]
        end
    end

    // helper for the period check only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap   <= '0;
            clean <= 1'b0;
        end else begin
            gap   <= (tick || restart) ? '0 : gap + 1'b1;
            clean <= tick ? 1'b1 : ((restart || period != $past(period)) ? 1'b0 : clean);
        end
    end

    period_gap_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
        tick && clean && $stable(period) |-> gap == period - 1'b1)
        else $error("timer period differs from programmed value");

endmodule : pst_timer_osc

// [core/pst_sequencer.sv]
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// [RULE1] after reset all three rails stay inactive until enable is asserted; with polarity high the pins are low (active) until 3 clocks after reset
// [RULE2] first rail activates nine to ten timer periods after enable rises
// [RULE3] after first rail, restart timer at charge start; second rail eight periods later
// [RULE4] third rail activates eight timer periods after the second
// [RULE5] enable low: third rail drops after the nine to ten period delay
// [RULE6] then second, then first rail drop, each eight periods apart
// [RULE7] timer period scales linearly with capacitance, 130 us per nF
// [RULE8] enable low before first rail: counter resets, no output changes
// [RULE9] enable low mid power-up: active rails drop in reverse order
// [RULE10] rails are open drain; active means released, released in order 1-2-3; with polarity high the code drives active rails low
// [RULE11] polarity low gives active-high rails, polarity high gives active-low
// [RULE12] the system always drives the polarity input to a defined level
// [RULE13] enable is synchronised to the core clock before any use
module pst_sequencer #(
    parameter int unsigned CYC_PER_NF = pst_pkg::CYC_PER_NF
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 seq_enable,
    input  wire logic                 output_polarity_select,
    input  wire pst_pkg::pst_rail_type rail_level_in,
    output pst_pkg::pst_rail_type     rail_out,
    output pst_pkg::pst_rail_type     rail_oe_n
);

    logic                             en_meta;
    logic                             en_sync;
    logic                             pol_meta;
    logic                             pol_sync;
    pst_pkg::pst_rail_type            lvl_meta;
    pst_pkg::pst_rail_type            lvl_sync;

    logic [pst_pkg::CAP_WIDTH-1:0]    timing_capacitor_node;
    logic [pst_pkg::CAP_WIDTH-1:0]    cap_eff;
    logic [pst_pkg::PERIOD_WIDTH-1:0] period;

    pst_pkg::pst_state_type           state;
    logic [3:0]                       tick_cnt;
    pst_pkg::pst_rail_type            rail_active;
    logic                             restart;
    logic                             charging;
    logic                             tick;

    logic                             setup;
    logic                             access;
    logic                             hit_ctrl;
    logic                             hit_status;
    logic [31:0]                      status_word;

    // drop the highest active rail
    function automatic pst_pkg::pst_rail_type drop_top(input pst_pkg::pst_rail_type r);
        pst_pkg::pst_rail_type d;
        d = r;
        if (r.rail_out_third) begin
            d.rail_out_third = 1'b0;
        end else if (r.rail_out_second) begin
            d.rail_out_second = 1'b0;
        end else begin
            d.rail_out_first = 1'b0;
        end
        return d;
    endfunction : drop_top

    // pins come from outside the core clock domain
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end else begin
            en_meta <= seq_enable; // [RULE13]
            en_sync <= en_meta;
        end
    end

    // polarity strap is static in use but still synchronised
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_meta <= 1'b0;
            pol_sync <= 1'b0;
        end else begin
            pol_meta <= output_polarity_select;
            pol_sync <= pol_meta;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_meta <= '0;
            lvl_sync <= '0;
        end else begin
            lvl_meta <= rail_level_in;
            lvl_sync <= lvl_meta;
        end
    end

    // a zero capacitance setting would stall the timer
    assign cap_eff = (timing_capacitor_node == '0) ? 8'h01 : timing_capacitor_node;
    assign period  = pst_pkg::PERIOD_WIDTH'(cap_eff * CYC_PER_NF); // [RULE7]

    pst_timer_osc u_osc (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .period   (period),
        .restart  (restart),
        .charging (charging),
        .tick     (tick)
    );

    // sequencer; restart is a one-cycle pulse into the timer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= pst_pkg::ST_IDLE;
            tick_cnt    <= 4'h0;
            rail_active <= '0; // [RULE1]
            restart     <= 1'b0;
        end else begin
            restart <= 1'b0;
            unique case (state)
                pst_pkg::ST_IDLE: begin
                    tick_cnt <= 4'h0;
                    if (en_sync) begin
                        state <= pst_pkg::ST_UP_FIRST; // [RULE1]
                    end
                end
                pst_pkg::ST_UP_FIRST: begin
                    if (!en_sync) begin
                        state    <= pst_pkg::ST_IDLE; // [RULE8]
                        tick_cnt <= 4'h0;
                    end else if (tick) begin
                        if (tick_cnt == pst_pkg::FIRST_TICKS - 4'h1) begin
                            rail_active.rail_out_first <= 1'b1; // [RULE2]
                            restart                    <= 1'b1; // [RULE3]
                            tick_cnt                   <= 4'h0;
                            state                      <= pst_pkg::ST_UP_SEC;
                        end else begin
                            tick_cnt <= tick_cnt + 4'h1;
                        end
                    end
                end
                pst_pkg::ST_UP_SEC: begin
                    if (!en_sync) begin
                        state    <= pst_pkg::ST_DN_FIRST; // [RULE9]
                        tick_cnt <= 4'h0;
                    end else if (tick) begin
                        if (tick_cnt == pst_pkg::NEXT_TICKS - 4'h1) begin
                            rail_active.rail_out_second <= 1'b1; // [RULE3]
                            restart                     <= 1'b1;
                            tick_cnt                    <= 4'h0;
                            state                       <= pst_pkg::ST_UP_THIRD;
                        end else begin
                            tick_cnt <= tick_cnt + 4'h1;
                        end
                    end
                end
                pst_pkg::ST_UP_THIRD: begin
                    if (!en_sync) begin
                        state    <= pst_pkg::ST_DN_FIRST; // [RULE9]
                        tick_cnt <= 4'h0;
                    end else if (tick) begin
                        if (tick_cnt == pst_pkg::NEXT_TICKS - 4'h1) begin
                            rail_active.rail_out_third <= 1'b1; // [RULE4]
                            tick_cnt                   <= 4'h0;
                            state                      <= pst_pkg::ST_ON;
                        end else begin
                            tick_cnt <= tick_cnt + 4'h1;
                        end
                    end
                end
                pst_pkg::ST_ON: begin
                    tick_cnt <= 4'h0;
                    if (!en_sync) begin
                        state <= pst_pkg::ST_DN_FIRST;
                    end
                end
                // no restart here, so the first down delay is nine to ten periods
                pst_pkg::ST_DN_FIRST: begin
                    if (tick) begin
                        if (tick_cnt == pst_pkg::FIRST_TICKS - 4'h1) begin
                            rail_active <= drop_top(rail_active); // [RULE5]
                            restart     <= 1'b1;
                            tick_cnt    <= 4'h0;
                            state       <= rail_active.rail_out_second ? pst_pkg::ST_DN_NEXT : pst_pkg::ST_IDLE;
                        end else begin
                            tick_cnt <= tick_cnt + 4'h1;
                        end
                    end
                end
                // enable rising again is served only once all rails are down
                pst_pkg::ST_DN_NEXT: begin
                    if (tick) begin
                        if (tick_cnt == pst_pkg::NEXT_TICKS - 4'h1) begin
                            rail_active <= drop_top(rail_active); // [RULE6]
                            restart     <= 1'b1;
                            tick_cnt    <= 4'h0;
                            state       <= rail_active.rail_out_second ? pst_pkg::ST_DN_NEXT : pst_pkg::ST_IDLE;
                        end else begin
                            tick_cnt <= tick_cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    state       <= pst_pkg::ST_IDLE;
                    tick_cnt    <= 4'h0;
                    rail_active <= '0;
                end
            endcase
        end
    end

    // open drain: data is always low, the enable alone sets the level
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_out  <= '0;
            rail_oe_n <= '0;
        end else begin
            rail_out  <= '0; // [RULE10]
            rail_oe_n <= rail_active ^ {3{pol_sync}}; // [RULE11]
        end
    end

    // apb slave, zero wait states
    assign setup      = psel && !penable;
    assign access     = psel && penable && pready;
    assign hit_ctrl   = (paddr == pst_pkg::CTRL_OFFSET);
    assign hit_status = (paddr == pst_pkg::STATUS_OFFSET);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[pst_pkg::STAT_STATE_LSB +: 3]  = state;
        status_word[pst_pkg::STAT_ACTIVE_LSB +: 3] = rail_active;
        status_word[pst_pkg::STAT_LEVEL_LSB +: 3]  = lvl_sync;
        status_word[pst_pkg::STAT_EN_BIT]          = en_sync;
        status_word[pst_pkg::STAT_POL_BIT]         = pol_sync;
        status_word[pst_pkg::STAT_CHARGE_BIT]      = charging;
        status_word[pst_pkg::STAT_TICKS_LSB +: 4]  = tick_cnt;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit_ctrl && !hit_status;
            if (setup && !pwrite && hit_ctrl) begin
                prdata <= 32'(timing_capacitor_node) << pst_pkg::CAP_LSB;
            end else if (setup && !pwrite && hit_status) begin
                prdata <= status_word;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // only the low byte lane holds a field; status is read only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timing_capacitor_node <= pst_pkg::CAP_RESET;
        end else if (access && pwrite && hit_ctrl && pstrb[0]) begin
            timing_capacitor_node <= pwdata[pst_pkg::CAP_LSB +: pst_pkg::CAP_WIDTH]; // [RULE7]
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence first_rail_due;
        $past(state) == pst_pkg::ST_UP_FIRST && $past(tick) && $past(tick_cnt) == pst_pkg::FIRST_TICKS - 4'h1;
    endsequence

    sequence next_rail_due;
        $past(tick) && $past(tick_cnt) == pst_pkg::NEXT_TICKS - 4'h1;
    endsequence

    sequence glitch_low;
        state == pst_pkg::ST_UP_FIRST && !en_sync;
    endsequence

    idle_quiet_a: assert property (state == pst_pkg::ST_IDLE && $past(state) == pst_pkg::ST_IDLE |-> rail_active == '0) // [RULE1]
        else $error("rail active while idle");

    first_delay_a: assert property ($rose(rail_active.rail_out_first) |-> first_rail_due) // [RULE2]
        else $error("first rail not on tenth tick");

    second_delay_a: assert property ($rose(rail_active.rail_out_second) |-> next_rail_due and restart ##0 $past(state) == pst_pkg::ST_UP_SEC) // [RULE3]
        else $error("second rail not eight periods after first");

    // short periods allowed, so only the first charging cycle is checked
    restart_align_a: assert property ($rose(rail_active.rail_out_first) |-> restart ##1 (charging && !tick)) // [RULE3]
        else $error("timer not restarted at first rail");

    third_delay_a: assert property ($rose(rail_active.rail_out_third) |-> next_rail_due ##0 state == pst_pkg::ST_ON) // [RULE4]
        else $error("third rail not eight periods after second");

    down_first_a: assert property ($fell(rail_active.rail_out_third) |-> $past(state) == pst_pkg::ST_DN_FIRST && $past(tick_cnt) == pst_pkg::FIRST_TICKS - 4'h1) // [RULE5]
        else $error("third rail off at wrong tick");

    down_order_a: assert property ($fell(rail_active.rail_out_first) |-> !rail_active.rail_out_second && !rail_active.rail_out_third) // [RULE6]
        else $error("rails dropped out of order");

    glitch_reset_a: assert property (glitch_low |=> state == pst_pkg::ST_IDLE && tick_cnt == 4'h0 && rail_active == '0 ##1 rail_oe_n == {3{pol_sync}}) // [RULE8]
        else $error("enable glitch not absorbed");

    abort_down_a: assert property (state == pst_pkg::ST_UP_THIRD && !en_sync |=> state == pst_pkg::ST_DN_FIRST && rail_active.rail_out_second) // [RULE9]
        else $error("partial power-up not shut down");

    drain_only_a: assert property ($rose(rail_active.rail_out_second) |-> rail_active.rail_out_first ##0 rail_out == '0) // [RULE10]
        else $error("rail order or open-drain data broken");

    polarity_map_a: assert property (!pol_sync && $stable(pol_sync) && rail_active.rail_out_first |=> rail_oe_n.rail_out_first) // [RULE11]
        else $error("active-high rail not released");

    abort_second_a: assert property (state == pst_pkg::ST_UP_SEC && !en_sync |=> state == pst_pkg::ST_DN_FIRST && tick_cnt == 4'h0) // [RULE9]
        else $error("abort after first rail not shut down");

    order_up_a: assert property ($rose(rail_active.rail_out_third) |-> rail_active.rail_out_first && rail_active.rail_out_second) // [RULE10]
        else $error("third rail released out of order");

    count_hold_a: assert property (state == pst_pkg::ST_UP_FIRST |-> rail_active == '0) // [RULE8]
        else $error("rail active before first delay ends");

    down_second_a: assert property ($fell(rail_active.rail_out_second) |-> !rail_active.rail_out_third && $past(tick)) // [RULE6]
        else $error("second rail dropped off a tick or before third");

    first_drop_a: assert property ($fell(rail_active.rail_out_first) |-> state == pst_pkg::ST_IDLE) // [RULE6]
        else $error("sequencer not idle after last rail dropped");

    // zero wait states: ready always follows the setup cycle
    ready_pulse_a: assert property (setup |=> pready)
        else $error("apb ready missing after setup");

    bad_addr_a: assert property (setup && !hit_ctrl && !hit_status |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped address not refused");

endmodule : pst_sequencer

// [tb/pst_supply_model.sv]
`timescale 1ns/1ps
module pst_supply_model (
    input  wire pst_pkg::pst_rail_type rail_out,
    input  wire pst_pkg::pst_rail_type rail_oe_n,
    output pst_pkg::pst_rail_type      rail_wire
);
    // supply enable pins, each with a pull-up resistor
    // released pin floats up, pulled pin follows the low drive
    assign rail_wire = rail_oe_n | rail_out;
endmodule : pst_supply_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
    localparam int unsigned CYC = 4;
    logic                  core_clk               = 1'b0;
    logic                  rst_n                  = 1'b0;
    logic                  psel                   = 1'b0;
    logic                  penable                = 1'b0;
    logic                  pwrite                 = 1'b0;
    logic [11:0]           paddr                  = 12'h000;
    logic [31:0]           pwdata                 = 32'h0000_0000;
    logic [3:0]            pstrb                  = 4'hf;
    logic                  seq_enable             = 1'b0;
    logic                  output_polarity_select = 1'b0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    pst_pkg::pst_rail_type rail_out;
    pst_pkg::pst_rail_type rail_oe_n;
    pst_pkg::pst_rail_type rail_wire;
    int                    fails    = 0;
    int                    compares = 0;
    int                    cycles   = 0;
    int                    per      = 4;

    pst_sequencer #(.CYC_PER_NF(CYC)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .seq_enable(seq_enable), .output_polarity_select(output_polarity_select),
        .rail_level_in(rail_wire), .rail_out(rail_out), .rail_oe_n(rail_oe_n)
    );
    pst_supply_model i_supply (.rail_out(rail_out), .rail_oe_n(rail_oe_n), .rail_wire(rail_wire));

    always #12.5 core_clk = ~core_clk;

    task automatic final_report;
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // ceiling well above two full passes at the largest timer period
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            fails++;
            final_report();
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_range(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : check_range

    // holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        check_range(n, 1, 49);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_lvl(input int i, input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (rail_wire[i] !== lvl && n <= hi) begin
            @(posedge core_clk);
            n++;
        end
        check_range(n, lo, hi);
    endtask : wait_lvl

    // pin level seen on the wires for a set of active rails and a polarity
    function automatic logic [2:0] pin_level(input logic [2:0] active, input logic pol);
        return active ^ {3{pol}};
    endfunction : pin_level

    task automatic hold_lvl(input int n, input logic [2:0] exp);
        logic [2:0] seen;
        seen = exp;
        repeat (n) begin
            @(posedge core_clk);
            if (rail_wire !== exp) seen = rail_wire;
        end
        check_val({29'h0, seen}, {29'h0, exp});
    endtask : hold_lvl

    // act is the pin level of an active rail for the chosen polarity
    task automatic one_pass(input logic act);
        logic [31:0] rd;
        logic        err;
        int          g;
        g = 7 * per + $urandom % per;
        @(posedge core_clk);
        seq_enable <= 1'b1;
        repeat (g) @(posedge core_clk);
        seq_enable <= 1'b0;
        hold_lvl(12 * per, {3{~act}});
        seq_enable <= 1'b1;
        wait_lvl(0, act, 9 * per, 10 * per + 6);
        check_val({30'h0, rail_wire[2:1]}, {30'h0, {2{~act}}});
        wait_lvl(1, act, 8 * per - 2, 8 * per + 3);
        check_val({31'h0, rail_wire[2]}, {31'h0, ~act});
        wait_lvl(2, act, 8 * per - 2, 8 * per + 3);
        apb(1'b0, pst_pkg::STATUS_OFFSET, 32'h0000_0000, rd, err);
        check_val({29'h0, rd[6:4]}, 32'h0000_0007);
        check_val({29'h0, rd[10:8]}, {29'h0, pin_level(3'b111, ~act)});
        check_val({31'h0, rd[13]}, {31'h0, ~act});
        seq_enable <= 1'b0;
        wait_lvl(2, ~act, 9 * per, 10 * per + 6);
        check_val({31'h0, rail_wire[1]}, {31'h0, act});
        wait_lvl(1, ~act, 8 * per - 2, 8 * per + 3);
        wait_lvl(0, ~act, 8 * per - 2, 8 * per + 3);
        hold_lvl(4, {3{~act}});
        seq_enable <= 1'b1;
        wait_lvl(0, act, 9 * per, 10 * per + 6);
        repeat (3 * per) @(posedge core_clk);
        seq_enable <= 1'b0;
        wait_lvl(0, ~act, 9 * per, 10 * per + 6);
        check_val({30'h0, rail_wire[2:1]}, {30'h0, {2{~act}}});
        seq_enable <= 1'b1;
        wait_lvl(0, act, 9 * per, 10 * per + 6);
        wait_lvl(1, act, 8 * per - 2, 8 * per + 3);
        repeat (per) @(posedge core_clk);
        seq_enable <= 1'b0;
        wait_lvl(1, ~act, 9 * per, 10 * per + 6);
        check_val({31'h0, rail_wire[2]}, {31'h0, ~act});
        wait_lvl(0, ~act, 8 * per - 2, 8 * per + 3);
    endtask : one_pass

    initial begin
        logic [31:0] rd;
        logic        err;
        logic [7:0]  cap;
        void'($urandom(89));
        repeat (16) @(posedge core_clk);
        check_val({29'h0, rail_wire}, 32'h0000_0000);
        rst_n <= 1'b1;
        hold_lvl(40, 3'b000);
        apb(1'b0, pst_pkg::CTRL_OFFSET, 32'h0000_0000, rd, err);
        check_val(rd, {24'h0, pst_pkg::CAP_RESET});
        pstrb <= 4'he;
        apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h0000_0055, rd, err);
        pstrb <= 4'hf;
        apb(1'b0, pst_pkg::CTRL_OFFSET, 32'h0000_0000, rd, err);
        check_val(rd, {24'h0, pst_pkg::CAP_RESET});
        apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
        check_val({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, pst_pkg::STATUS_OFFSET, 32'hffff_ffff, rd, err);
        check_val({31'h0, err}, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            cap = 8'(1 + $urandom % 3);
            per = int'(cap) * CYC;
            apb(1'b1, pst_pkg::CTRL_OFFSET, {24'h0, cap}, rd, err);
            apb(1'b0, pst_pkg::CTRL_OFFSET, 32'h0000_0000, rd, err);
            check_val(rd, {24'h0, cap});
            // polarity always driven to a defined level
            output_polarity_select <= k[0];
            repeat (4) @(posedge core_clk);
            hold_lvl(8, {3{k[0]}});
            one_pass(~k[0]);
        end
        final_report();
    end
endmodule : tb
